// file: common/ssr_defines.vh
/*
  Register offsets, field positions and reset values of the synchronous
  serial receive/transmit block.
  Assumes a 32-bit classic Wishbone bus with one register per aligned word.
*/
`ifndef SSR_DEFINES_VH
`define SSR_DEFINES_VH

// ==========================================================================
// Register byte offsets
`define SSR_OFF_BAUD_CTL   8'h00
`define SSR_OFF_RX_DATA    8'h04
`define SSR_OFF_RX_STAT    8'h08
`define SSR_OFF_DIV_LOW    8'h0c
`define SSR_OFF_DIV_HIGH   8'h10
`define SSR_OFF_TX_DATA    8'h14
`define SSR_OFF_TX_STAT    8'h18
`define SSR_OFF_PERI_EN    8'h1c
`define SSR_OFF_PERI_FLAG  8'h20
`define SSR_OFF_INT_CTL    8'h24

// ==========================================================================
// Field positions
`define SSR_BC_IDLE        6
`define SSR_BC_CLK_POL     4
`define SSR_BC_WIDE        3
`define SSR_RS_PORT_EN     7
`define SSR_RS_NINE        6
`define SSR_RS_SINGLE      5
`define SSR_RS_CONT        4
`define SSR_RS_FRAMING     2
`define SSR_RS_OVERRUN     1
`define SSR_RS_NINTH       0
`define SSR_TS_MASTER      7
`define SSR_TS_NINE        6
`define SSR_TS_TX_EN       5
`define SSR_TS_CLOCKED     4
`define SSR_TS_HIGH_SPEED  2
`define SSR_TS_SHIFT_EMPTY 1
`define SSR_TS_NINTH       0
`define SSR_PE_RX          5
`define SSR_PE_TX          4
`define SSR_IC_GLOBAL      7
`define SSR_IC_PERI        6

// ==========================================================================
// Reset values and last bit indices
`define SSR_RST_BYTE       8'h00
`define SSR_RST_DIV        16'h0000
`define SSR_LAST_BIT_8     4'h7
`define SSR_LAST_BIT_9     4'h8

`endif

// file: core/ssr_core.v
/*
  Synchronous serial receiver/transmitter: Wishbone register slave, master
  clock generator, slave clock sampler, transmit buffer and shifter, receive
  shifter and two-entry receive queue, wake and interrupt requests.
  Assumes sys_clk at 25 MHz and a slave-mode pin clock far slower than it.
*/
`timescale 1ns/1ps
`include "ssr_defines.vh"
`default_nettype none

module ssr_core (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        arst_n,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Clock pin
  input  wire        clock_pin_i,
  output reg         clock_pin_o,
  output reg         clock_pin_oe,
  // Data pin
  input  wire        data_pin_i,
  output reg         data_pin_o,
  output reg         data_pin_oe,
  // Processor requests
  output reg         wake_request,
  output reg         irq_request
);

  // ========================================================================
  // Helpers
  function [3:0] last_bit;
    input nine;
    begin
      last_bit = nine ? `SSR_LAST_BIT_9 : `SSR_LAST_BIT_8;
    end
  endfunction

  function hit;
    input [7:0] adr;
    input [7:0] off;
    begin
      hit = (adr[7:2] == off[7:2]);
    end
  endfunction

  // ========================================================================
  // Reset release
  reg rst_s1;
  reg rst_n;
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // ========================================================================
  // Pin synchronisers
  reg ck_s1;
  reg ck_s2;
  reg ck_s3;
  reg dt_s1;
  reg dt_s2;
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ck_s1 <= 1'b0;
      ck_s2 <= 1'b0;
      ck_s3 <= 1'b0;
      dt_s1 <= 1'b0;
      dt_s2 <= 1'b0;
    end
    else
    begin
      ck_s1 <= clock_pin_i;
      ck_s2 <= ck_s1;
      ck_s3 <= ck_s2;
      dt_s1 <= data_pin_i;
      dt_s2 <= dt_s1;
    end
  end

  // ========================================================================
  // Configuration registers
  reg        clk_polarity;
  reg        wide_divisor_select;
  reg [7:0]  baud_divisor_low;
  reg [7:0]  baud_divisor_high;
  reg        port_enable;
  reg        nine_bit_receive_select;
  reg        single_receive_enable;
  reg        continuous_receive_enable;
  reg        clock_source_master;
  reg        nine_bit_transmit_select;
  reg        transmit_enable;
  reg        clocked_mode;
  reg        high_speed_baud_select;
  reg        transmit_ninth_bit;
  reg        receive_interrupt_enable;
  reg        transmit_interrupt_enable;
  reg        global_interrupt_enable;
  reg        peripheral_interrupt_enable;

  // Datapath state declared early for the bus read mux.
  reg [8:0]  rx_queue0;
  reg [8:0]  rx_queue1;
  reg [1:0]  rx_count;
  reg [7:0]  receive_shifter;
  reg [3:0]  rx_bit;
  reg        overrun_flag;
  reg [8:0]  tx_buffer;
  reg        tx_buffer_full;
  reg [8:0]  transmit_shifter;
  reg        tx_busy;
  reg [3:0]  tx_bit;

  wire bus_go  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire bus_wr  = bus_go & wb_we_i & wb_sel_i[0];
  wire unit_on = port_enable & clocked_mode;
  wire master  = unit_on & clock_source_master;
  wire slave   = unit_on & ~clock_source_master;
  wire tx_mode = ~single_receive_enable & ~continuous_receive_enable;
  // A slave receives only with the continuous-receive enable.
  wire rx_on   = unit_on & (continuous_receive_enable | (master & single_receive_enable));
  wire rx_pop  = bus_go & ~wb_we_i & hit(wb_adr_i, `SSR_OFF_RX_DATA) & (rx_count != 2'd0);
  wire receive_complete_flag = (rx_count != 2'd0);
  wire transmit_ready_flag   = ~tx_buffer_full;

  // ========================================================================
  // Bit clock events
  reg        ck_level;
  reg [15:0] div_cnt;
  wire [15:0] div_limit = wide_divisor_select ? {baud_divisor_high, baud_divisor_low}
                                              : {8'h00, baud_divisor_low};
  wire m_run  = master & ((tx_mode & tx_busy) | (rx_on & ~overrun_flag));
  wire m_tick = m_run & (div_cnt == div_limit);
  wire s_edge = slave & (ck_s2 != ck_s3);
  wire ev_lead  = master ? (m_tick & (ck_level == clk_polarity)) : (s_edge & (ck_s3 == clk_polarity));
  wire ev_trail = master ? (m_tick & (ck_level != clk_polarity)) : (s_edge & (ck_s2 == clk_polarity));

  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_cnt  <= `SSR_RST_DIV;
      ck_level <= 1'b0;
    end
    else if (!m_run)
    begin
      div_cnt  <= `SSR_RST_DIV;
      ck_level <= clk_polarity;
    end
    else if (m_tick)
    begin
      div_cnt  <= `SSR_RST_DIV;
      ck_level <= ~ck_level;
    end
    else
    begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end

  // ========================================================================
  // Receive path
  wire       rx_evt   = ev_trail & rx_on & ~overrun_flag & ~tx_mode;
  wire       rx_done  = rx_evt & (rx_bit == last_bit(nine_bit_receive_select));
  wire [8:0] rx_char  = nine_bit_receive_select ? {dt_s2, receive_shifter}
                                                : {1'b0, dt_s2, receive_shifter[6:0]};
  wire [1:0] cnt_left = rx_count - {1'b0, rx_pop};
  wire       rx_push  = rx_done & (cnt_left != 2'd2);
  wire       rx_ovr   = rx_done & (cnt_left == 2'd2);

  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_queue0       <= 9'h000;
      rx_queue1       <= 9'h000;
      rx_count        <= 2'd0;
      receive_shifter <= 8'h00;
      rx_bit          <= 4'h0;
      overrun_flag    <= 1'b0;
    end
    else if (!port_enable)
    begin
      // Port disable is the unit's soft reset.
      rx_queue0       <= 9'h000;
      rx_queue1       <= 9'h000;
      rx_count        <= 2'd0;
      receive_shifter <= 8'h00;
      rx_bit          <= 4'h0;
      overrun_flag    <= 1'b0;
    end
    else
    begin
      if (rx_pop)
        rx_queue0 <= rx_queue1;
      if (rx_push)
      begin
        if (cnt_left == 2'd0)
          rx_queue0 <= rx_char;
        else
          rx_queue1 <= rx_char;
      end
      rx_count <= cnt_left + {1'b0, rx_push};
      if (!rx_on || tx_mode)
        rx_bit <= 4'h0;
      else if (rx_done)
        rx_bit <= 4'h0;
      else if (rx_evt)
      begin
        receive_shifter[rx_bit[2:0]] <= dt_s2;
        rx_bit <= rx_bit + 4'h1;
      end
      // A new overrun wins over any clear in the same cycle.
      if (rx_ovr)
        overrun_flag <= 1'b1;
      else if (!continuous_receive_enable && !single_receive_enable)
        overrun_flag <= 1'b0;
      else if (!continuous_receive_enable && rx_pop)
        overrun_flag <= 1'b0;
    end
  end

  // ========================================================================
  // Transmit path
  wire tx_run  = unit_on & transmit_enable & tx_mode;
  wire tx_done = ev_trail & tx_busy & (tx_bit == last_bit(nine_bit_transmit_select));
  wire tx_load = tx_run & tx_buffer_full & (~tx_busy | tx_done);
  wire tx_wr   = bus_wr & hit(wb_adr_i, `SSR_OFF_TX_DATA);

  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_buffer        <= 9'h000;
      tx_buffer_full   <= 1'b0;
      transmit_shifter <= 9'h000;
      tx_busy          <= 1'b0;
      tx_bit           <= 4'h0;
      data_pin_o       <= 1'b0;
    end
    else if (!port_enable)
    begin
      tx_buffer_full   <= 1'b0;
      transmit_shifter <= 9'h000;
      tx_busy          <= 1'b0;
      tx_bit           <= 4'h0;
      data_pin_o       <= 1'b0;
    end
    else
    begin
      if (!tx_run)
      begin
        tx_busy <= 1'b0;
        tx_bit  <= 4'h0;
      end
      else
      begin
        if (ev_lead && tx_busy)
          data_pin_o <= transmit_shifter[tx_bit];
        if (tx_done)
        begin
          tx_busy <= 1'b0;
          tx_bit  <= 4'h0;
        end
        else if (ev_trail && tx_busy)
          tx_bit <= tx_bit + 4'h1;
      end
      if (tx_load)
      begin
        transmit_shifter <= tx_buffer;
        tx_busy          <= 1'b1;
        tx_buffer_full   <= 1'b0;
      end
      // A write in the load cycle refills the freed buffer.
      if (tx_wr)
      begin
        tx_buffer      <= {transmit_ninth_bit, wb_dat_i[7:0]};
        tx_buffer_full <= 1'b1;
      end
    end
  end

  // ========================================================================
  // Register writes and bus answer
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clk_polarity                <= 1'b0;
      wide_divisor_select         <= 1'b0;
      baud_divisor_low            <= `SSR_RST_BYTE;
      baud_divisor_high           <= `SSR_RST_BYTE;
      port_enable                 <= 1'b0;
      nine_bit_receive_select     <= 1'b0;
      single_receive_enable       <= 1'b0;
      continuous_receive_enable   <= 1'b0;
      clock_source_master         <= 1'b0;
      nine_bit_transmit_select    <= 1'b0;
      transmit_enable             <= 1'b0;
      clocked_mode                <= 1'b0;
      high_speed_baud_select      <= 1'b0;
      transmit_ninth_bit          <= 1'b0;
      receive_interrupt_enable    <= 1'b0;
      transmit_interrupt_enable   <= 1'b0;
      global_interrupt_enable     <= 1'b0;
      peripheral_interrupt_enable <= 1'b0;
      wb_ack_o                    <= 1'b0;
      wb_dat_o                    <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= bus_go;
      // The single-receive enable drops after one character in master mode.
      if (rx_done && master)
        single_receive_enable <= 1'b0;
      if (bus_wr)
      begin
        if (hit(wb_adr_i, `SSR_OFF_BAUD_CTL))
        begin
          clk_polarity        <= wb_dat_i[`SSR_BC_CLK_POL];
          wide_divisor_select <= wb_dat_i[`SSR_BC_WIDE];
        end
        if (hit(wb_adr_i, `SSR_OFF_DIV_LOW))
          baud_divisor_low <= wb_dat_i[7:0];
        if (hit(wb_adr_i, `SSR_OFF_DIV_HIGH))
          baud_divisor_high <= wb_dat_i[7:0];
        if (hit(wb_adr_i, `SSR_OFF_RX_STAT))
        begin
          port_enable               <= wb_dat_i[`SSR_RS_PORT_EN];
          nine_bit_receive_select   <= wb_dat_i[`SSR_RS_NINE];
          single_receive_enable     <= wb_dat_i[`SSR_RS_SINGLE];
          continuous_receive_enable <= wb_dat_i[`SSR_RS_CONT];
        end
        if (hit(wb_adr_i, `SSR_OFF_TX_STAT))
        begin
          clock_source_master      <= wb_dat_i[`SSR_TS_MASTER];
          nine_bit_transmit_select <= wb_dat_i[`SSR_TS_NINE];
          transmit_enable          <= wb_dat_i[`SSR_TS_TX_EN];
          clocked_mode             <= wb_dat_i[`SSR_TS_CLOCKED];
          high_speed_baud_select   <= wb_dat_i[`SSR_TS_HIGH_SPEED];
          transmit_ninth_bit       <= wb_dat_i[`SSR_TS_NINTH];
        end
        if (hit(wb_adr_i, `SSR_OFF_PERI_EN))
        begin
          receive_interrupt_enable  <= wb_dat_i[`SSR_PE_RX];
          transmit_interrupt_enable <= wb_dat_i[`SSR_PE_TX];
        end
        if (hit(wb_adr_i, `SSR_OFF_INT_CTL))
        begin
          global_interrupt_enable     <= wb_dat_i[`SSR_IC_GLOBAL];
          peripheral_interrupt_enable <= wb_dat_i[`SSR_IC_PERI];
        end
      end
      wb_dat_o <= 32'h00000000;
      if (bus_go && !wb_we_i)
      begin
        case ({wb_adr_i[7:2], 2'b00})
          `SSR_OFF_BAUD_CTL:
            wb_dat_o[7:0] <= {1'b0, (rx_bit == 4'h0), 1'b0, clk_polarity, wide_divisor_select, 3'b000};
          `SSR_OFF_RX_DATA:
            wb_dat_o[7:0] <= rx_queue0[7:0];
          `SSR_OFF_RX_STAT:
            wb_dat_o[7:0] <= {port_enable, nine_bit_receive_select, single_receive_enable,
                              continuous_receive_enable, 1'b0, 1'b0, overrun_flag,
                              rx_queue0[8]};
          `SSR_OFF_DIV_LOW:
            wb_dat_o[7:0] <= baud_divisor_low;
          `SSR_OFF_DIV_HIGH:
            wb_dat_o[7:0] <= baud_divisor_high;
          `SSR_OFF_TX_STAT:
            wb_dat_o[7:0] <= {clock_source_master, nine_bit_transmit_select, transmit_enable,
                              clocked_mode, 1'b0, high_speed_baud_select, ~tx_busy,
                              transmit_ninth_bit};
          `SSR_OFF_PERI_EN:
            wb_dat_o[7:0] <= {2'b00, receive_interrupt_enable, transmit_interrupt_enable, 4'h0};
          `SSR_OFF_PERI_FLAG:
            wb_dat_o[7:0] <= {2'b00, receive_complete_flag, transmit_ready_flag, 4'h0};
          `SSR_OFF_INT_CTL:
            wb_dat_o[7:0] <= {global_interrupt_enable, peripheral_interrupt_enable, 6'h00};
          default:
            wb_dat_o[7:0] <= 8'h00;
        endcase
      end
    end
  end

  // ========================================================================
  // Pin drivers and processor requests
  // Wake is computed from the flags, their enables and the peripheral enable, without the global enable, so it works while the core sleeps.
  wire wake_next = peripheral_interrupt_enable &
                   ((receive_complete_flag & receive_interrupt_enable) |
                    (transmit_ready_flag & transmit_interrupt_enable));

  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clock_pin_o  <= 1'b0;
      clock_pin_oe <= 1'b0;
      data_pin_oe  <= 1'b0;
      wake_request <= 1'b0;
      irq_request  <= 1'b0;
    end
    else
    begin
      clock_pin_o  <= ck_level;
      clock_pin_oe <= master;
      data_pin_oe  <= unit_on & tx_mode;
      wake_request <= wake_next;
      irq_request  <= wake_next & global_interrupt_enable;
    end
  end

endmodule // ssr_core

`default_nettype wire

// file: verif/ssr_core_props.sv
/* Concurrent checks on the ports of ssr_core, bound to every instance.
   Assumes control bits change only through Wishbone writes with sel[0] set. */
`timescale 1ns/1ps
`include "ssr_defines.vh"
`default_nettype none
module ssr_core_props (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        arst_n,
  // Register bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Pins
  input wire logic        clock_pin_i,
  input wire logic        clock_pin_o,
  input wire logic        clock_pin_oe,
  input wire logic        data_pin_i,
  input wire logic        data_pin_o,
  input wire logic        data_pin_oe,
  // Requests
  input wire logic        wake_request,
  input wire logic        irq_request
);
  // ==========
  // Shadow of control bits. The single-receive shadow may stay set after the block clears it,
  // so it is only used where a stale one makes a check weaker, never wrong.
  logic       sh_port, sh_single, sh_cont, sh_clocked, sh_master, sh_global, sh_peri;
  wire        take  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire        wr_ok = take && wb_we_i && wb_sel_i[0];
  wire  [7:0] adr   = {wb_adr_i[7:2], 2'b00};
  always @(posedge sys_clk or negedge arst_n)
    if (!arst_n)
      {sh_port, sh_single, sh_cont, sh_clocked, sh_master, sh_global, sh_peri} <= 7'h00;
    else if (wr_ok)
    begin
      if (adr == `SSR_OFF_RX_STAT)
        {sh_port, sh_single, sh_cont} <= {wb_dat_i[`SSR_RS_PORT_EN], wb_dat_i[`SSR_RS_SINGLE], wb_dat_i[`SSR_RS_CONT]};
      if (adr == `SSR_OFF_TX_STAT)
        {sh_master, sh_clocked} <= {wb_dat_i[`SSR_TS_MASTER], wb_dat_i[`SSR_TS_CLOCKED]};
      if (adr == `SSR_OFF_INT_CTL)
        {sh_global, sh_peri} <= {wb_dat_i[`SSR_IC_GLOBAL], wb_dat_i[`SSR_IC_PERI]};
    end
  // ==========
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  ack_follows_a: assert property (take |=> wb_ack_o) else $error("ack missing after request");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  read_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper read bits set");
  slave_clock_a: assert property (clock_pin_oe |-> $past(sh_master && sh_port && sh_clocked))
    else $error("clock pin driven outside master mode");
  tx_oe_off_a: assert property (data_pin_oe |-> $past(sh_port && sh_clocked && !sh_cont))
    else $error("data pin driven while receiving");
  tx_oe_on_a: assert property ($past(sh_port && sh_clocked && !sh_cont && !sh_single) |-> data_pin_oe)
    else $error("data pin not driven as transmitter");
  irq_wake_a: assert property (irq_request |-> wake_request) else $error("irq without wake");
  irq_global_a: assert property (irq_request |-> $past(sh_global)) else $error("irq with global off");
  wake_peri_a: assert property (wake_request |-> $past(sh_peri)) else $error("wake with peripheral off");
  ovr_clear_a: assert property (take && !wb_we_i && adr == `SSR_OFF_RX_STAT && !sh_cont && !sh_single
    && !$past(sh_cont) |=> !wb_dat_o[`SSR_RS_OVERRUN]) else $error("overrun kept with receive off");
  cover property (irq_request);
  cover property (clock_pin_oe && $rose(clock_pin_o));
  cover property (data_pin_oe && $changed(data_pin_o));
endmodule // ssr_core_props
bind ssr_core ssr_core_props chk_u (.sys_clk(sys_clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .clock_pin_i(clock_pin_i), .clock_pin_o(clock_pin_o),
  .clock_pin_oe(clock_pin_oe), .data_pin_i(data_pin_i), .data_pin_o(data_pin_o),
  .data_pin_oe(data_pin_oe), .wake_request(wake_request), .irq_request(irq_request));
`default_nettype wire

// file: verif/ssr_link_model.sv
/* External synchronous master on the link: makes the shift clock, sends and samples data.
   Assumes clock idle low, so the leading edge rises and the trailing edge falls. */
`timescale 1ns/1ps
`default_nettype none
module ssr_link_model (
  // Pins driven toward the block
  output logic       link_clk,
  output logic       link_dat,
  // Resolved data pin level
  input  wire logic  pin_dat
);
  initial
  begin
    link_clk = 1'b0;
    link_dat = 1'b0;
  end
  // ==========
  // One frame of n bits, LSB first, 320 ns per bit after a gap that sets the spacing between frames.
  // The clock stands still between frames and the data line is driven to the inverse of the last bit.
  task automatic frame(input logic [8:0] w, input int n, input int gap, output logic [8:0] got);
    got = 9'h000;
    #(gap);
    for (int i = 0; i < n; i++)
    begin
      link_clk = 1'b1;
      link_dat = w[i];
      #160;
      link_clk = 1'b0;
      got[i] = pin_dat;
      #160;
    end
    link_dat = ~link_dat;
  endtask
endmodule // ssr_link_model
`default_nettype wire

// file: verif/tb_top.sv
/* Self-checking bench for ssr_core: slave receive and transmit, overrun, port disable, master receive.
   Assumes the link model stands on the far side of the clock and data pins. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        sys_clk, arst_n, wb_cyc_i, wb_stb_i, wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  wire  [31:0] wb_dat_o;
  wire         wb_ack_o, clock_pin_o, clock_pin_oe, data_pin_o, data_pin_oe, wake_request, irq_request;
  wire         m_clk, m_dat;
  wire         clock_pin_i = clock_pin_oe ? clock_pin_o : m_clk;
  // Neither pin shares an analog function here, so there is nothing to switch off.
  wire         data_pin_i  = data_pin_oe ? data_pin_o : m_dat;
  int          n_mismatch, tests_run, n_clk;
  logic [31:0] exp_q[$], msk_q[$];
  logic [8:0]  w[4];
  logic [8:0]  got;

  ssr_core dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .clock_pin_i(clock_pin_i), .clock_pin_o(clock_pin_o), .clock_pin_oe(clock_pin_oe),
    .data_pin_i(data_pin_i), .data_pin_o(data_pin_o), .data_pin_oe(data_pin_oe),
    .wake_request(wake_request), .irq_request(irq_request));
  ssr_link_model link_u (.link_clk(m_clk), .link_dat(m_dat), .pin_dat(data_pin_i));

  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge clock_pin_o)
    if (clock_pin_oe === 1'b1)
      n_clk++;
  // ==========
  // Checking and closing
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge sys_clk)
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
    begin
      if (exp_q.size() == 0)
        chk("unexpected read", 32'h1, 32'h0);
      else
        chk("read data", wb_dat_o & msk_q.pop_front(), exp_q.pop_front());
    end
  // ==========
  // Bus cycles and waits
  task automatic wb_io(input logic we, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e,
                       input logic [7:0] m);
    logic [31:0] r;
    logic        done;
    r    = $urandom();
    done = 1'b0;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_sel_i <= r[27:24] | 4'h1;
    wb_dat_i <= {r[23:0], d};
    if (!we)
    begin
      exp_q.push_back({24'h0, e & m});
      msk_q.push_back({24'hffffff, m});
    end
    for (int k = 0; k < 20 && !done; k++)
    begin
      @(posedge sys_clk);
      done = (wb_ack_o === 1'b1);
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (!done)
    begin
      n_mismatch++;
      end_sim();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb_io(1'b1, a, d, 8'h00, 8'h00);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    wb_io(1'b0, a, 8'h00, e, m);
  endtask
  task automatic wait_wake(input logic lvl);
    for (int k = 0; k < 200 && wake_request !== lvl; k++)
      @(posedge sys_clk);
    chk("wake request", {31'h0, wake_request}, {31'h0, lvl});
    if (wake_request !== lvl)
      end_sim();
  endtask
  // ==========
  // Main sequence
  initial
  begin
    {arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    n_mismatch = 0;
    tests_run  = 0;
    void'($urandom(67));
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    for (int i = 0; i < 4; i++)
      w[i] = 9'($urandom());
    // Slave nine-bit reception of two characters back to back.
    wr(8'h18, 8'h10);
    wr(8'h1c, 8'h20);
    wr(8'h24, 8'hc0);
    wr(8'h08, 8'hd0);
    link_u.frame(w[0], 9, 1013, got);
    link_u.frame(w[1], 9, 0, got);
    wait_wake(1'b1);
    chk("irq request", {31'h0, irq_request}, 32'h1);
    rd(8'h20, 8'h20, 8'h20);
    rd(8'h08, 8'hd0 | w[0][8], 8'hf1);
    rd(8'h04, w[0][7:0], 8'hff);
    rd(8'h08, {7'h0, w[1][8]}, 8'h01);
    rd(8'h04, w[1][7:0], 8'hff);
    rd(8'h20, 8'h00, 8'h20);
    // Four eight-bit characters into a two-entry queue, then overrun release.
    wr(8'h08, 8'h90);
    for (int i = 0; i < 4; i++)
      link_u.frame(w[i], 8, 97, got);
    repeat (10) @(posedge sys_clk);
    rd(8'h08, 8'h02, 8'h02);
    rd(8'h04, w[0][7:0], 8'hff);
    rd(8'h04, w[1][7:0], 8'hff);
    rd(8'h20, 8'h00, 8'h20);
    wr(8'h08, 8'h80);
    rd(8'h08, 8'h80, 8'h82);
    // Port disable empties a queue holding one character.
    wr(8'h08, 8'h90);
    link_u.frame(w[2], 8, 211, got);
    wait_wake(1'b1);
    wr(8'h08, 8'h10);
    wr(8'h08, 8'h90);
    rd(8'h20, 8'h00, 8'h20);
    wait_wake(1'b0);
    rd(8'h3c, 8'h00, 8'hff);
    // Slave transmission of two buffered characters.
    wr(8'h08, 8'h80);
    wr(8'h1c, 8'h10);
    wr(8'h18, 8'h30);
    rd(8'h20, 8'h10, 8'h10);
    wr(8'h14, w[2][7:0]);
    wr(8'h14, w[3][7:0]);
    rd(8'h20, 8'h00, 8'h10);
    rd(8'h18, 8'h30, 8'hf2);
    wait_wake(1'b0);
    chk("data pin enable", {31'h0, data_pin_oe}, 32'h1);
    link_u.frame(9'h000, 8, 301, got);
    chk("first sent", {24'h0, got[7:0]}, {24'h0, w[2][7:0]});
    wait_wake(1'b1);
    chk("irq request", {31'h0, irq_request}, 32'h1);
    rd(8'h20, 8'h10, 8'h10);
    link_u.frame(9'h000, 8, 53, got);
    chk("second sent", {24'h0, got[7:0]}, {24'h0, w[3][7:0]});
    // Master single-character reception.
    wr(8'h08, 8'h00);
    rd(8'h08, 8'h00, 8'h30);
    wr(8'h18, 8'h90);
    wr(8'h10, 8'h00);
    wr(8'h0c, 8'h01);
    wr(8'h1c, 8'h20);
    n_clk = 0;
    wr(8'h08, 8'ha0);
    wait_wake(1'b1);
    repeat (20) @(posedge sys_clk);
    chk("master clocks", n_clk, 32'd8);
    rd(8'h08, 8'h80, 8'ha0);
    end_sim();
  end
  initial
  begin
    #2000000;
    n_mismatch++;
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
